// [hdl/cca_map.svh]
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// register offsets (byte addresses on the 8-bit register port)
`define CCA_ADR_CTRL 8'h00
`define CCA_ADR_MODE 8'h01
`define CCA_ADR_CNT_LO 8'h02
`define CCA_ADR_CNT_HI 8'h03
`define CCA_ADR_MOD_MODE 8'h10
`define CCA_ADR_MOD_LO 8'h18
`define CCA_ADR_MOD_HI 8'h20
`define CCA_ADR_MOD_MASK 8'hF8
`define CCA_ADR_IDX_MASK 8'h07

// array_control_reg fields
`define CCA_CTRL_OVF 7
`define CCA_CTRL_RUN 6

// array_mode_reg fields
`define CCA_MODE_IDLE_HALT 7
`define CCA_MODE_TB_HI 2
`define CCA_MODE_TB_LO 1
`define CCA_MODE_OVF_IE 0

// module_mode_reg fields
`define CCA_MM_CMP_EN 6
`define CCA_MM_RISE 5
`define CCA_MM_FALL 4
`define CCA_MM_HIT 3
`define CCA_MM_FLIP 2
`define CCA_MM_PWM 1
`define CCA_MM_IE 0

// timebase
`define CCA_DIV12 4'hB
`define CCA_DIV4 4'h3
`define CCA_TB_DIV12 2'h0
`define CCA_TB_DIV4 2'h1
`define CCA_TB_T0 2'h2
`define CCA_TB_EXT 2'h3

// reset values and limits
`define CCA_ZERO8 8'h00
`define CCA_ZERO16 16'h0000
`define CCA_ONES8 8'hFF
`define CCA_ONES16 16'hFFFF

`endif

// [hdl/cca_pkg.sv]
package cca_pkg;

  localparam int unsigned NUM_MODULES = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0] presc;
    logic [7:0] held_hi;
    logic ovf_flag;
    logic run;
    logic idle_halt;
    logic [1:0] tb_sel;
    logic ovf_ie;
    logic ext_prev;
    logic [NUM_MODULES-1:0][6:0] mode;
    logic [NUM_MODULES-1:0][15:0] value;
    logic [NUM_MODULES-1:0] event_flag;
    logic [NUM_MODULES-1:0] pin_out;
    logic [NUM_MODULES-1:0] pin_prev;
    logic [7:0] rdata;
  } state_s;

endpackage : cca_pkg

// [hdl/counter_array.sv]
// Summary of operation
// - two-bit select picks counter timebase
// - counter wrap to zero sets overflow flag
// - overflow request needs overflow enable bit
// - overflow flag cleared only by software
// - low byte read latches high byte
// - counter reads never disturb counting
// - idle halt clear keeps running in idle
// - requests need global and array enables
// - one counter, five modules, own pins
// - each module configured independently
// - module request needs its enable bit
// - trigger enables choose capture edge
// - capture copies counter, sets event flag
// - event flags cleared only by software
// - compare hit sets module event flag
// - match flip toggles module pin
// - pwm needs comparator and pwm bits
// - pwm pin high on low byte match
// - pwm pin low on low byte overflow
// - pwm low value reloads from high
//
// Added by the designer: the address map and the address-and-strobe port.
`include "cca_map.svh"
`timescale 1ns/1ps
`default_nettype none

module counter_array #(
  parameter int unsigned N = cca_pkg::NUM_MODULES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire cca_pkg::bus_req_s I_BUS_REQ,
  output logic [7:0] O_RDATA,
  input wire logic I_T0_OVF,
  input wire logic I_EXT_COUNT,
  input wire logic I_CORE_IDLE,
  input wire logic I_GLOBAL_IRQ_EN,
  input wire logic I_ARRAY_IRQ_EN,
  input wire logic [N-1:0] I_MODULE_PIN,
  output logic [N-1:0] O_MODULE_PIN,
  output logic [N-1:0] O_MODULE_PIN_OE,
  output logic O_IRQ
);
  import cca_pkg::*;

  state_s r;
  state_s next_r;

  logic tick;
  logic halted;
  logic [3:0] presc_limit;
  logic presc_hit;
  logic ext_fall;
  logic [15:0] cnt_inc;
  logic low_wrap;
  logic [7:0] idx;
  logic is_mod_mode;
  logic is_mod_lo;
  logic is_mod_hi;
  logic [N-1:0] mod_irq;

  // address decode of module register groups
  always_comb begin
    idx = I_BUS_REQ.addr & `CCA_ADR_IDX_MASK;
    is_mod_mode = ((I_BUS_REQ.addr & `CCA_ADR_MOD_MASK) == `CCA_ADR_MOD_MODE)
                  && (idx < 8'(N));
    is_mod_lo = ((I_BUS_REQ.addr & `CCA_ADR_MOD_MASK) == `CCA_ADR_MOD_LO)
                && (idx < 8'(N));
    is_mod_hi = ((I_BUS_REQ.addr & `CCA_ADR_MOD_MASK) == `CCA_ADR_MOD_HI)
                && (idx < 8'(N));
  end

  // timebase selection
  always_comb begin
    halted = !r.run || (r.idle_halt && I_CORE_IDLE);
    presc_limit = (r.tb_sel == `CCA_TB_DIV12) ? `CCA_DIV12 : `CCA_DIV4;
    // at or past the limit, so a switch from /12 to /4 never stalls a tick
    presc_hit = (r.presc >= presc_limit);
    ext_fall = r.ext_prev && !I_EXT_COUNT;
    case (r.tb_sel)
      `CCA_TB_DIV12: tick = presc_hit;
      `CCA_TB_DIV4: tick = presc_hit;
      `CCA_TB_T0: tick = I_T0_OVF;
      `CCA_TB_EXT: tick = ext_fall;
      default: tick = 1'b0;
    endcase
    if (halted) begin
      tick = 1'b0;
    end
    cnt_inc = r.cnt + 16'h0001;
    low_wrap = tick && (r.cnt[7:0] == `CCA_ONES8);
  end

  always_comb begin
    logic [6:0] m;
    logic rise;
    logic fall;
    logic hit;
    m = '0;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    next_r = r;
    next_r.ext_prev = I_EXT_COUNT;
    next_r.pin_prev = I_MODULE_PIN;
    next_r.rdata = `CCA_ZERO8;

    // prescaler runs only while counting is allowed
    if (halted || presc_hit) begin
      next_r.presc = '0;
    end else begin
      next_r.presc = r.presc + 4'h1;
    end

    // software writes; hardware sets below win over clears
    if (I_BUS_REQ.wr) begin
      case (I_BUS_REQ.addr)
        `CCA_ADR_CTRL: begin
          next_r.ovf_flag = I_BUS_REQ.wdata[`CCA_CTRL_OVF];
          next_r.run = I_BUS_REQ.wdata[`CCA_CTRL_RUN];
          next_r.event_flag = I_BUS_REQ.wdata[N-1:0];
        end
        `CCA_ADR_MODE: begin
          next_r.idle_halt = I_BUS_REQ.wdata[`CCA_MODE_IDLE_HALT];
          next_r.tb_sel = {I_BUS_REQ.wdata[`CCA_MODE_TB_HI],
                           I_BUS_REQ.wdata[`CCA_MODE_TB_LO]};
          next_r.ovf_ie = I_BUS_REQ.wdata[`CCA_MODE_OVF_IE];
        end
        `CCA_ADR_CNT_LO: next_r.cnt[7:0] = I_BUS_REQ.wdata;
        `CCA_ADR_CNT_HI: next_r.cnt[15:8] = I_BUS_REQ.wdata;
        default: begin
          if (is_mod_mode) begin
            next_r.mode[idx[2:0]] = I_BUS_REQ.wdata[6:0];
          end
          if (is_mod_lo) begin
            next_r.value[idx[2:0]][7:0] = I_BUS_REQ.wdata;
          end
          if (is_mod_hi) begin
            next_r.value[idx[2:0]][15:8] = I_BUS_REQ.wdata;
          end
        end
      endcase
    end

    // reads: registered data, low byte read freezes high byte
    if (I_BUS_REQ.rd) begin
      case (I_BUS_REQ.addr)
        `CCA_ADR_CTRL: begin
          next_r.rdata = `CCA_ZERO8;
          next_r.rdata[`CCA_CTRL_OVF] = r.ovf_flag;
          next_r.rdata[`CCA_CTRL_RUN] = r.run;
          next_r.rdata[N-1:0] = r.event_flag;
        end
        `CCA_ADR_MODE: begin
          next_r.rdata[`CCA_MODE_IDLE_HALT] = r.idle_halt;
          next_r.rdata[`CCA_MODE_TB_HI] = r.tb_sel[1];
          next_r.rdata[`CCA_MODE_TB_LO] = r.tb_sel[0];
          next_r.rdata[`CCA_MODE_OVF_IE] = r.ovf_ie;
        end
        `CCA_ADR_CNT_LO: begin
          next_r.rdata = r.cnt[7:0];
          next_r.held_hi = r.cnt[15:8];
        end
        `CCA_ADR_CNT_HI: next_r.rdata = r.held_hi;
        default: begin
          if (is_mod_mode) begin
            next_r.rdata = {1'b0, r.mode[idx[2:0]]};
          end
          if (is_mod_lo) begin
            next_r.rdata = r.value[idx[2:0]][7:0];
          end
          if (is_mod_hi) begin
            next_r.rdata = r.value[idx[2:0]][15:8];
          end
        end
      endcase
    end

    // counting overrides a simultaneous counter write
    if (tick) begin
      next_r.cnt = cnt_inc;
      if (r.cnt == `CCA_ONES16) begin
        next_r.ovf_flag = 1'b1;
      end
    end

    // capture/compare modules
    for (int i = 0; i < N; i++) begin
      m = r.mode[i];
      rise = !r.pin_prev[i] && I_MODULE_PIN[i];
      fall = r.pin_prev[i] && !I_MODULE_PIN[i];
      hit = tick && (cnt_inc == r.value[i]);
      if (!m[`CCA_MM_HIT] && !m[`CCA_MM_FLIP] && !m[`CCA_MM_PWM]) begin
        if ((m[`CCA_MM_RISE] && rise) || (m[`CCA_MM_FALL] && fall)) begin
          next_r.value[i] = r.cnt;
          next_r.event_flag[i] = 1'b1;
        end
      end else if (m[`CCA_MM_CMP_EN] && m[`CCA_MM_PWM]) begin
        if (low_wrap) begin
          next_r.pin_out[i] = 1'b0;
          next_r.value[i][7:0] = r.value[i][15:8];
        end else if (tick && (cnt_inc[7:0] == r.value[i][7:0])) begin
          next_r.pin_out[i] = 1'b1;
        end
      end else if (m[`CCA_MM_CMP_EN] && m[`CCA_MM_HIT] && hit) begin
        next_r.event_flag[i] = 1'b1;
        if (m[`CCA_MM_FLIP]) begin
          next_r.pin_out[i] = !r.pin_out[i];
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs and interrupt request
  always_comb begin
    for (int i = 0; i < N; i++) begin
      mod_irq[i] = r.event_flag[i] && r.mode[i][`CCA_MM_IE];
      O_MODULE_PIN_OE[i] = r.mode[i][`CCA_MM_CMP_EN]
                           && ((r.mode[i][`CCA_MM_HIT] && r.mode[i][`CCA_MM_FLIP])
                               || r.mode[i][`CCA_MM_PWM]);
    end
    O_IRQ = I_GLOBAL_IRQ_EN && I_ARRAY_IRQ_EN
            && ((r.ovf_flag && r.ovf_ie) || (|mod_irq));
    O_MODULE_PIN = r.pin_out;
    O_RDATA = r.rdata;
  end

endmodule : counter_array

`default_nettype wire

// [tb/pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic i_clk,
  input wire logic [4:0] i_level,
  output logic [4:0] o_pin,
  output logic o_ext,
  output logic o_t0
);
  logic [1:0] phase;
  initial begin
    phase = 2'h0;
    o_pin = 5'h00;
    o_ext = 1'b0;
    o_t0 = 1'b0;
  end
  always @(posedge i_clk) begin
    phase <= phase + 2'h1;
    o_pin <= i_level;
    o_ext <= phase[1];
    o_t0 <= phase == 2'h3;
  end
endmodule : pin_partner
`default_nettype wire

// [tb/counter_array_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module counter_array_monitor #(
  parameter int unsigned N = 5
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire cca_pkg::bus_req_s I_BUS_REQ,
  input wire logic [7:0] O_RDATA,
  input wire logic I_GLOBAL_IRQ_EN,
  input wire logic I_ARRAY_IRQ_EN,
  input wire logic [N-1:0] O_MODULE_PIN,
  input wire logic [N-1:0] O_MODULE_PIN_OE,
  input wire logic O_IRQ
);
  import cca_pkg::*;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence s_stop;
    I_BUS_REQ.wr && I_BUS_REQ.addr == 8'h00 && !I_BUS_REQ.wdata[6];
  endsequence
  sequence s_rd_lo;
    I_BUS_REQ.rd && I_BUS_REQ.addr == 8'h02;
  endsequence
  property p_gate;
    O_IRQ |-> I_GLOBAL_IRQ_EN && I_ARRAY_IRQ_EN;
  endproperty
  a_gate: assert property (p_gate) else $error("irq gate");
  property p_hold;
    O_IRQ && !I_BUS_REQ.wr |=> O_IRQ || !I_GLOBAL_IRQ_EN || !I_ARRAY_IRQ_EN;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_halt;
    s_stop ##1 s_rd_lo ##1 s_rd_lo |=> O_RDATA == $past(O_RDATA);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved");
  property p_quiet;
    O_MODULE_PIN_OE == '0 |=> $stable(O_MODULE_PIN);
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin moved");
  property p_pwm_oe;
    I_BUS_REQ.wr && I_BUS_REQ.addr == 8'h14 && I_BUS_REQ.wdata[6] && I_BUS_REQ.wdata[1]
      |=> O_MODULE_PIN_OE[4];
  endproperty
  a_pwm_oe: assert property (p_pwm_oe) else $error("pwm not driving");
  property p_mode_rb;
    I_BUS_REQ.wr && I_BUS_REQ.addr == 8'h10 ##1 I_BUS_REQ.rd && I_BUS_REQ.addr == 8'h10
      |=> (O_RDATA & 8'h7F) == ($past(I_BUS_REQ.wdata, 2) & 8'h7F);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_unmapped;
    I_BUS_REQ.rd && I_BUS_REQ.addr == 8'h15 |=> O_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("sixth module");
  property p_rd_idle;
    !I_BUS_REQ.rd |=> O_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
endmodule : counter_array_monitor
bind counter_array counter_array_monitor #(.N(N)) counter_array_monitor_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_BUS_REQ(I_BUS_REQ), .O_RDATA(O_RDATA),
  .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN), .I_ARRAY_IRQ_EN(I_ARRAY_IRQ_EN),
  .O_MODULE_PIN(O_MODULE_PIN), .O_MODULE_PIN_OE(O_MODULE_PIN_OE), .O_IRQ(O_IRQ));
`default_nettype wire

// [tb/counter_array_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module counter_array_bench;
  import cca_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic idle = 1'b0;
  logic gie = 1'b1;
  logic aie = 1'b1;
  bus_req_s req = '0;
  logic [4:0] lvl = 5'h00;
  logic [7:0] rdata, md;
  logic [4:0] mpin, oe, ppin;
  logic t0, ext, irq;
  int failures = 0;
  int checks = 0;
  wire [4:0] pin_w = (oe & mpin) | (~oe & ppin);
  always #2 clk = ~clk;
  pin_partner pin_partner_i (.i_clk(clk), .i_level(lvl), .o_pin(ppin), .o_ext(ext), .o_t0(t0));
  counter_array counter_array_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_BUS_REQ(req),
    .O_RDATA(rdata), .I_T0_OVF(t0), .I_EXT_COUNT(ext), .I_CORE_IDLE(idle),
    .I_GLOBAL_IRQ_EN(gie), .I_ARRAY_IRQ_EN(aie), .I_MODULE_PIN(pin_w),
    .O_MODULE_PIN(mpin), .O_MODULE_PIN_OE(oe), .O_IRQ(irq));
  task stop_test;
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, e);
    checks++;
    if (got !== e) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task op(input logic [7:0] ad, dt, input logic w, r);
    @(posedge clk) req <= {ad, dt, w, r};
  endtask : op
  task wr(input logic [7:0] ad, dt);
    op(ad, dt, 1'b1, 1'b0);
    op(8'h00, 8'h00, 1'b0, 1'b0);
  endtask : wr
  task rd(input logic [7:0] ad, e, m);
    op(ad, 8'h00, 1'b0, 1'b1);
    op(8'h00, 8'h00, 1'b0, 1'b0);
    #1 chk(rdata & m, e);
  endtask : rd
  // low byte advance over 48 clocks, reads in between
  task meas(input logic [7:0] e);
    logic [7:0] s;
    op(8'h02, 8'h00, 1'b0, 1'b1);
    op(8'h02, 8'h00, 1'b0, 1'b1);
    #1 s = rdata;
    op(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (45) @(posedge clk);
    rd(8'h02, s + e, 8'hFF);
  endtask : meas
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch %0t timeout", $time);
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 8'h00, 8'hFF);
    rd(8'h15, 8'h00, 8'hFF);
    wr(8'h00, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, 8'(i << 1));
      meas((i == 0) ? 8'h04 : 8'h0C);
    end
    @(posedge clk) idle <= 1'b1;
    wr(8'h01, 8'h82);
    meas(8'h00);
    wr(8'h01, 8'h02);
    meas(8'h0C);
    @(posedge clk) idle <= 1'b0;
    op(8'h00, 8'h00, 1'b1, 1'b0);
    meas(8'h00);
    wr(8'h03, 8'h12);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'hFF, 8'hFF);
    wr(8'h00, 8'h40);
    repeat (8) @(posedge clk);
    rd(8'h03, 8'h12, 8'hFF);
    wr(8'h00, 8'h00);
    wr(8'h03, 8'hFF);
    wr(8'h02, 8'hFF);
    wr(8'h01, 8'h03);
    wr(8'h00, 8'h40);
    repeat (8) @(posedge clk);
    rd(8'h00, 8'h80, 8'h80);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk) gie <= 1'b0;
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk) gie <= 1'b1;
    aie <= 1'b0;
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk) aie <= 1'b1;
    #1 chk({7'h00, irq}, 8'h01);
    wr(8'h01, 8'h02);
    #1 chk({7'h00, irq}, 8'h00);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h00, 8'h80);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h1B, 8'h05);
    wr(8'h13, 8'h4C);
    wr(8'h00, 8'h40);
    repeat (30) @(posedge clk);
    chk({7'h00, mpin[3]}, 8'h01);
    rd(8'h00, 8'h08, 8'h08);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h1C, 8'h40);
    wr(8'h24, 8'hC0);
    wr(8'h14, 8'h42);
    wr(8'h00, 8'h40);
    repeat (300) @(posedge clk);
    chk({7'h00, mpin[4]}, 8'h01);
    repeat (800) @(posedge clk);
    chk({7'h00, mpin[4]}, 8'h00);
    rd(8'h1C, 8'hC0, 8'hFF);
    wr(8'h00, 8'h00);
    for (int m = 0; m < 3; m++) begin
      md = (m == 0) ? 8'h20 : (m == 1) ? 8'h10 : 8'h30;
      op(8'h10 + 8'(m), md, 1'b1, 1'b0);
      rd(8'h10 + 8'(m), md, 8'h7F);
      wr(8'h02, 8'h11);
      @(posedge clk) lvl[m] <= 1'b1;
      repeat (4) @(posedge clk);
      wr(8'h02, 8'h22);
      @(posedge clk) lvl[m] <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h18 + 8'(m), (m == 0) ? 8'h11 : 8'h22, 8'hFF);
    end
    rd(8'h00, 8'h07, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(8'h10, 8'h21);
    #1 chk({7'h00, irq}, 8'h01);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00, 8'h1F);
    wr(8'h00, 8'h5F);
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 8'h00, 8'hFF);
    chk({7'h00, irq}, 8'h00);
    stop_test;
  end
endmodule : counter_array_bench
`default_nettype wire
